/* File: verif/mrad_bus_model.sv */
// Bus slave model answering each access once, promptly or after a wait.
// Assumes the decoder holds bus_valid until it samples bus_done.
`timescale 1ns/10ps
`default_nettype none
module mrad_bus_model #(
    parameter logic [31:0] RDATA = 32'h44332211
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic bus_valid,
    input wire logic slow,
    input wire logic err_on,
    output logic bus_done,
    output logic bus_error,
    output logic [31:0] bus_rdata
);
    logic [1:0] wait_cnt;
    // Idle read lines toggle so a sample taken one cycle after done never looks right
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bus_done <= 1'b0;
            bus_error <= 1'b0;
            bus_rdata <= 32'h0;
            wait_cnt <= 2'h0;
        end else if (bus_valid && !bus_done) begin
            wait_cnt <= wait_cnt + 2'h1;
            if (!slow || wait_cnt == 2'h3) begin
                bus_done <= 1'b1;
                bus_error <= err_on;
                bus_rdata <= RDATA;
                wait_cnt <= 2'h0;
            end
        end else begin
            bus_done <= 1'b0;
            bus_error <= 1'b0;
            bus_rdata <= ~bus_rdata;
        end
    end
endmodule : mrad_bus_model
`default_nettype wire

/* File: verif/mrad_props.sv */
// Checker for the region decoder, watching only the top module's ports.
// Assumes binding to mrad_top and a single clock domain.
`timescale 1ns/10ps
`default_nettype none
`include "mrad_regs.svh"
module mrad_props
    import mrad_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic rsp_error,
    input wire logic fetch_valid,
    input wire logic [31:0] fetch_addr,
    input wire logic hard_fault_exception,
    input wire logic instruction_sync_barrier,
    input wire logic barrier_busy,
    input wire logic exec_stall,
    input wire logic prefetch_flush,
    input wire logic bus_valid,
    input wire logic bus_write,
    input wire logic [31:0] bus_addr,
    input wire logic [3:0] bus_strb,
    input wire mrad_mtype_t bus_mtype,
    input wire logic bus_done,
    input wire logic bus_error
);
    function automatic mrad_mtype_t mt(input logic [31:0] a);
        if (a >= `MRAD_PPR_BASE && a <= `MRAD_PPR_END) return MRAD_STRONG;
        if (a <= `MRAD_SRAM_END || (a > `MRAD_PERIPH_END && a <= `MRAD_EXTRAM_END))
            return MRAD_NORMAL;
        return MRAD_DEVICE;
    endfunction : mt
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_map_type: assert property (bus_valid |-> bus_mtype == mt(bus_addr))
        else $error("bus type differs from map");
    a_ppr_word: assert property (bus_valid && bus_mtype == MRAD_STRONG |-> bus_strb == 4'hF)
        else $error("sub-word strongly ordered access");
    a_xn_fault: assert property (fetch_valid && mt(fetch_addr) != MRAD_NORMAL
        |=> hard_fault_exception) else $error("no fault on protected fetch");
    a_posted_dev: assert property (req_ready && rsp_valid && !rsp_error
        |-> bus_valid && bus_write && bus_mtype == MRAD_DEVICE) else $error("bad posted write");
    a_read_rsp: assert property (bus_valid && bus_done && !bus_write
        |=> rsp_valid && rsp_error == $past(bus_error)) else $error("read answer lost");
    a_drain_block: assert property (barrier_busy |-> !req_ready)
        else $error("request taken while draining");
    a_sync_stall: assert property (exec_stall |-> barrier_busy)
        else $error("stall without drain");
    a_isb_flush: assert property ($rose(instruction_sync_barrier) && !bus_valid
        && !barrier_busy |=> prefetch_flush) else $error("no prefetch flush");
endmodule : mrad_props
`default_nettype wire

/* File: verif/mrad_top_test.sv */
// Self-checking bench for the region decoder with a bus slave model.
// Assumes the checker is bound to every decoder instance.
`timescale 1ns/10ps
`default_nettype none
module mrad_top_test
    import mrad_pkg::*;
;
    localparam logic [31:0] W = 32'h44332211;
    logic clk_sys, rst, req_valid, req_write, req_shareable, fetch_valid, slow, err_on;
    logic data_memory_barrier, data_sync_barrier, instruction_sync_barrier;
    logic [1:0] req_size;
    logic [31:0] req_addr, req_wdata, fetch_addr, rsp_rdata, bus_addr, bus_wdata, bus_rdata;
    logic req_ready, rsp_valid, rsp_error, hard_fault_exception, barrier_busy, exec_stall;
    logic prefetch_flush, bus_valid, bus_write, bus_done, bus_error;
    logic [3:0] bus_strb;
    mrad_mtype_t bus_mtype;
    int miscompares, n_compared;
    logic [31:0] fa [12] = '{32'h1FFFFFFF, 32'h3FFFFFFF, 32'h40000000, 32'h5FFFFFFF,
        32'h60000000, 32'h9FFFFFFF, 32'hA0000000, 32'hDFFFFFFF, 32'hE0000000,
        32'hE00FFFFF, 32'hE0100000, 32'hFFFFFFFF};
    logic [11:0] fx = 12'b0011_0011_1111;
    mrad_top u_mrad_top (
        .clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req_write(req_write),
        .req_shareable(req_shareable), .req_size(req_size), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_error(rsp_error), .rsp_rdata(rsp_rdata), .fetch_valid(fetch_valid),
        .fetch_addr(fetch_addr), .hard_fault_exception(hard_fault_exception),
        .data_memory_barrier(data_memory_barrier), .data_sync_barrier(data_sync_barrier),
        .instruction_sync_barrier(instruction_sync_barrier), .barrier_busy(barrier_busy),
        .exec_stall(exec_stall), .prefetch_flush(prefetch_flush), .bus_valid(bus_valid),
        .bus_write(bus_write), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_strb(bus_strb), .bus_mtype(bus_mtype), .bus_done(bus_done),
        .bus_error(bus_error), .bus_rdata(bus_rdata)
    );
    mrad_bus_model #(.RDATA(W)) u_mrad_bus_model (
        .clk_sys(clk_sys), .rst(rst), .bus_valid(bus_valid), .slow(slow), .err_on(err_on),
        .bus_done(bus_done), .bus_error(bus_error), .bus_rdata(bus_rdata)
    );
    always #5 clk_sys = ~clk_sys;
    task automatic chk(input logic [31:0] g, e);
        n_compared++;
        if (g !== e) begin
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
            miscompares++;
        end
    endtask : chk
    task automatic finish_test();
        if (miscompares == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    // One data access, judged at acceptance and at its answer
    task automatic acc(input logic wr, sh, input logic [1:0] sz, input logic [31:0] a, d,
                       input mrad_mtype_t mt, input logic err, bus);
        logic [3:0] es;
        logic hf;
        int k;
        es = sz == 0 ? 4'h1 << a[1:0] : sz == 1 ? (a[1] ? 4'hC : 4'h3) : 4'hF;
        {req_write, req_shareable, req_size, req_addr, req_wdata} = {wr, sh, sz, a, d};
        req_valid = 1;
        k = 0;
        hf = 0;
        do begin @(negedge clk_sys); k++; end while (req_ready !== 1 && k < 50);
        req_valid = 0;
        chk(req_ready, 1);
        chk(bus_valid, bus);
        if (bus) begin
            chk(bus_mtype, mt);
            chk(bus_write, wr);
            chk(bus_strb, es);
            chk(bus_addr[31:2], a[31:2]);
            for (int j = 0; j < 4; j++)
                if (wr && es[j]) chk(bus_wdata[8*j+:8], d[8*(j-a[1:0])+:8]);
        end
        k = 0;
        while (rsp_valid !== 1 && k < 50) begin
            hf |= hard_fault_exception;
            @(negedge clk_sys);
            k++;
        end
        chk(rsp_valid, 1);
        chk(rsp_error, err);
        if (!wr && !err)
            chk(rsp_rdata, (W >> 8 * a[1:0]) & ~(32'hFFFFFFFF << (8 << sz)));
        hf |= hard_fault_exception;
        @(negedge clk_sys);
        chk(hf | hard_fault_exception, err);
    endtask : acc
    task automatic fetch(input logic [31:0] a, input logic xn);
        logic hf;
        fetch_addr = a;
        fetch_valid = 1;
        @(negedge clk_sys);
        fetch_valid = 0;
        hf = hard_fault_exception;
        @(negedge clk_sys);
        chk(hf | hard_fault_exception, xn);
    endtask : fetch
    // Barrier held until taken, then drained: 0 memory, 1 sync, 2 instruction
    task automatic bar(input int kind);
        int k;
        logic st;
        st = 0;
        k = 0;
        {data_memory_barrier, data_sync_barrier, instruction_sync_barrier} = 3'b100 >> kind;
        do begin @(negedge clk_sys); k++; st |= exec_stall; end
        while (barrier_busy !== 1 && prefetch_flush !== 1 && k < 50);
        {data_memory_barrier, data_sync_barrier, instruction_sync_barrier} = 3'b000;
        chk(k < 50, 1);
        while (barrier_busy === 1 && k < 100) begin
            @(negedge clk_sys);
            k++;
            st |= exec_stall;
        end
        chk(bus_valid, 0);
        if (kind < 2) chk(st, kind == 1);
        else chk(prefetch_flush, 1);
    endtask : bar
    initial begin
        {clk_sys, req_valid, req_write, req_shareable, fetch_valid, slow, err_on} = 0;
        {data_memory_barrier, data_sync_barrier, instruction_sync_barrier} = 0;
        {req_size, req_addr, req_wdata, fetch_addr} = 0;
        {miscompares, n_compared} = 0;
        rst = 1;
        repeat (20) @(negedge clk_sys);
        rst = 0;
        @(negedge clk_sys);
        acc(0, 0, 2, 32'h00000100, 0, MRAD_NORMAL, 0, 1);
        acc(0, 0, 0, 32'h20000002, 0, MRAD_NORMAL, 0, 1);
        acc(0, 0, 1, 32'h9FFFFFFE, 0, MRAD_NORMAL, 0, 1);
        acc(1, 0, 0, 32'h40000003, 32'h5A, MRAD_DEVICE, 0, 1);
        acc(0, 0, 2, 32'hE0000000, 0, MRAD_STRONG, 0, 1);
        acc(1, 1, 1, 32'hA0000002, 32'hBEEF, MRAD_DEVICE, 0, 1);
        acc(1, 0, 2, 32'hE0000004, 32'h12345678, MRAD_STRONG, 0, 1);
        acc(0, 0, 2, 32'hE0100000, 0, MRAD_DEVICE, 0, 1);
        acc(1, 0, 0, 32'hE0000001, 32'h1, MRAD_NORMAL, 1, 0);
        acc(0, 0, 1, 32'hE0000002, 0, MRAD_NORMAL, 1, 0);
        for (int i = 0; i < 12; i++) fetch(fa[i], fx[11-i]);
        slow = 1;
        acc(1, 0, 2, 32'h5FFFFFFC, 32'hCAFEF00D, MRAD_DEVICE, 0, 1);
        bar(0);
        acc(1, 0, 2, 32'h40000008, 32'h1, MRAD_DEVICE, 0, 1);
        bar(1);
        bar(2);
        err_on = 1;
        acc(0, 0, 2, 32'h20000010, 0, MRAD_NORMAL, 1, 1);
        finish_test();
    end
    initial begin
        #200000;
        miscompares++;
        finish_test();
    end
endmodule : mrad_top_test
bind mrad_top mrad_props u_mrad_props (
    .clk_sys(clk_sys), .rst(rst), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_error(rsp_error), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
    .hard_fault_exception(hard_fault_exception),
    .instruction_sync_barrier(instruction_sync_barrier), .barrier_busy(barrier_busy),
    .exec_stall(exec_stall), .prefetch_flush(prefetch_flush), .bus_valid(bus_valid),
    .bus_write(bus_write), .bus_addr(bus_addr), .bus_strb(bus_strb), .bus_mtype(bus_mtype),
    .bus_done(bus_done), .bus_error(bus_error)
);
`default_nettype wire

/* File: verilog/mrad_pkg.sv */
// Types shared by the region decoder files.
// Assumes nothing of its surroundings.
package mrad_pkg;
    typedef enum logic [1:0] {
        MRAD_NORMAL = 2'h0,
        MRAD_DEVICE = 2'h1,
        MRAD_STRONG = 2'h2
    } mrad_mtype_t;
endpackage : mrad_pkg

/* File: verilog/mrad_region_decode.sv */
// Combinational address map decode into memory type and execute-never attribute.
// Assumes a 32-bit byte address.
`timescale 1ns/10ps
`default_nettype none
`include "mrad_regs.svh"
module mrad_region_decode
    import mrad_pkg::*;
(
    input wire logic [31:0] addr,
    output mrad_mtype_t mtype,
    output logic execute_never_attr,
    output logic private_peripheral_region
);
    always_comb begin
        mtype = MRAD_DEVICE;
        execute_never_attr = 1'b1;
        private_peripheral_region = 1'b0;
        if (addr <= `MRAD_SRAM_END) begin
            mtype = MRAD_NORMAL;
            execute_never_attr = 1'b0;
        end else if (addr <= `MRAD_PERIPH_END) begin
            mtype = MRAD_DEVICE;
        end else if (addr <= `MRAD_EXTRAM_END) begin
            mtype = MRAD_NORMAL;
            execute_never_attr = 1'b0;
        end else if (addr <= `MRAD_EXTDEV_END) begin
            mtype = MRAD_DEVICE;
        end else if (addr <= `MRAD_PPR_END) begin
            mtype = MRAD_STRONG;
            private_peripheral_region = 1'b1;
        end else begin
            mtype = MRAD_DEVICE;
        end
    end
endmodule : mrad_region_decode
`default_nettype wire

/* File: verilog/mrad_regs.svh */
// Address map bounds and bus constants for the region decoder.
// Assumes inclusion by its bare name from design files.
`ifndef MRAD_REGS_SVH
`define MRAD_REGS_SVH
// ****************************************************************
// Region bounds (inclusive upper ends, plus the private peripheral and vendor bases)
// ****************************************************************
`define MRAD_CODE_END 32'h1FFFFFFF
`define MRAD_SRAM_END 32'h3FFFFFFF
`define MRAD_PERIPH_END 32'h5FFFFFFF
`define MRAD_EXTRAM_END 32'h9FFFFFFF
`define MRAD_EXTDEV_END 32'hDFFFFFFF
`define MRAD_PPR_BASE 32'hE0000000
`define MRAD_PPR_END 32'hE00FFFFF
`define MRAD_VENDOR_BASE 32'hE0100000
// ****************************************************************
// Access sizes
// ****************************************************************
`define MRAD_SIZE_BYTE 2'h0
`define MRAD_SIZE_HALF 2'h1
`define MRAD_SIZE_WORD 2'h2
`endif

/* File: verilog/mrad_top.sv */
// Memory region attribute decoder: decodes the fixed map, orders accesses,
// holds one buffered Device write, runs barriers and places bytes little-endian.
// Assumes the core holds a request stable until accepted and the bus slave
// answers each issued access once with done, optionally with error.
//
// Function
// - Decode one fixed 4GB map into regions
// - Code, SRAM, external RAM are executable Normal
// - Normal accesses may reorder, speculative reads allowed
// - Peripheral, external, vendor ranges are Device, ordered
// - Private peripheral range: Strongly-ordered, word only
// - Strongly-ordered kept in order with everything
// - Device writes bufferable, Strongly-ordered never buffered
// - Fetch from execute-never region raises hard fault
// - Device/strong pairs per table keep program order
// - No order guaranteed for Normal pairs
// - Reordering never changes single-stream behaviour
// - Memory barrier drains before next transaction
// - Sync barrier drains before next instruction
// - Instruction barrier flushes prefetched instructions
// - Bytes numbered upward, four per word
// - Words stored least significant byte first
// - Byte, halfword and word data sizes
// - Fetches and private peripheral always little-endian
`timescale 1ns/10ps
`default_nettype none
`include "mrad_regs.svh"
module mrad_top
    import mrad_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    // Core data request
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_shareable,
    input wire logic [1:0] req_size,
    input wire logic [31:0] req_addr,
    input wire logic [31:0] req_wdata,
    output logic req_ready,
    output logic rsp_valid,
    output logic rsp_error,
    output logic [31:0] rsp_rdata,
    // Core fetch check
    input wire logic fetch_valid,
    input wire logic [31:0] fetch_addr,
    output logic hard_fault_exception,
    // Barriers
    input wire logic data_memory_barrier,
    input wire logic data_sync_barrier,
    input wire logic instruction_sync_barrier,
    output logic barrier_busy,
    output logic exec_stall,
    output logic prefetch_flush,
    // Bus side
    output logic bus_valid,
    output logic bus_write,
    output logic [31:0] bus_addr,
    output logic [31:0] bus_wdata,
    output logic [3:0] bus_strb,
    output mrad_mtype_t bus_mtype,
    input wire logic bus_done,
    input wire logic bus_error,
    input wire logic [31:0] bus_rdata
);
    // ****************************************************************
    // Decode
    // ****************************************************************
    mrad_mtype_t req_mtype;
    logic req_ppr;
    logic fetch_xn;

    // Data side needs the type and the word-only region; execute-never only
    // matters for fetches, so each copy leaves its other outputs open
    mrad_region_decode u_req_dec (
        .addr(req_addr),
        .mtype(req_mtype),
        .execute_never_attr(),
        .private_peripheral_region(req_ppr)
    );
    // Fetch side sees only the execute-never flag; fetches never reach
    // the data bus through this block, so their type is not needed
    mrad_region_decode u_fetch_dec (
        .addr(fetch_addr),
        .mtype(),
        .execute_never_attr(fetch_xn),
        .private_peripheral_region()
    );

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    typedef enum logic [1:0] {
        MRAD_IDLE = 2'h0,
        MRAD_BUSY = 2'h1,
        MRAD_DRAIN = 2'h2
    } mrad_state_t;

    mrad_state_t state, next_state;
    logic buf_full, next_buf_full;
    logic busy_buffered, next_busy_buffered;
    logic [1:0] bar_kind, next_bar_kind;
    logic [1:0] low_addr, next_low_addr;
    logic [1:0] low_size, next_low_size;
    logic next_req_ready, next_rsp_valid, next_rsp_error;
    logic [31:0] next_rsp_rdata;
    logic next_hard_fault, next_barrier_busy, next_exec_stall, next_prefetch_flush;
    logic next_bus_valid, next_bus_write;
    logic [31:0] next_bus_addr, next_bus_wdata;
    logic [3:0] next_bus_strb;
    mrad_mtype_t next_bus_mtype;

    logic [3:0] strb;
    logic [31:0] lane_wdata;
    logic [31:0] lane_rdata;
    logic size_bad;

    // Little-endian lane placement: byte n of a word sits at address offset n
    always_comb begin
        strb = 4'hF;
        lane_wdata = req_wdata;
        case (req_size)
            `MRAD_SIZE_BYTE: begin
                strb = 4'h1 << req_addr[1:0];
                lane_wdata = {4{req_wdata[7:0]}};
            end
            `MRAD_SIZE_HALF: begin
                strb = req_addr[1] ? 4'hC : 4'h3;
                lane_wdata = {2{req_wdata[15:0]}};
            end
            default: begin
                strb = 4'hF;
                lane_wdata = req_wdata;
            end
        endcase
    end

    // Lanes are picked with the offset captured at issue, since req_addr may have moved on
    always_comb begin
        case (low_size)
            `MRAD_SIZE_BYTE: lane_rdata = {24'h000000, bus_rdata[{low_addr, 3'h0} +: 8]};
            `MRAD_SIZE_HALF: lane_rdata = {16'h0000, bus_rdata[{low_addr[1], 4'h0} +: 16]};
            default: lane_rdata = bus_rdata;
        endcase
    end

    // Sub-word private peripheral access is answered locally, never reaches the bus
    assign size_bad = req_ppr && (req_size != `MRAD_SIZE_WORD);

    always_comb begin
        next_state = state;
        next_buf_full = buf_full;
        next_busy_buffered = busy_buffered;
        next_bar_kind = bar_kind;
        next_low_addr = low_addr;
        next_low_size = low_size;
        next_req_ready = 1'b0;
        next_rsp_valid = 1'b0;
        next_rsp_error = 1'b0;
        next_rsp_rdata = rsp_rdata;
        next_hard_fault = 1'b0;
        next_prefetch_flush = 1'b0;
        next_barrier_busy = barrier_busy;
        next_exec_stall = exec_stall;
        next_bus_valid = bus_valid;
        next_bus_write = bus_write;
        next_bus_addr = bus_addr;
        next_bus_wdata = bus_wdata;
        next_bus_strb = bus_strb;
        next_bus_mtype = bus_mtype;
        // Fault only when the fetched word is actually executed; the core
        // raises fetch_valid for that, speculative prefetch is not checked
        if (fetch_valid && fetch_xn) begin
            next_hard_fault = 1'b1;
        end
        // Flush even mid-access: completed work is already visible to later fetches
        if (instruction_sync_barrier) begin
            next_prefetch_flush = 1'b1;
        end
        case (state)
            MRAD_IDLE: begin
                if (data_memory_barrier || data_sync_barrier) begin
                    next_state = MRAD_DRAIN;
                    next_bar_kind = {data_sync_barrier, data_memory_barrier};
                    next_barrier_busy = 1'b1;
                    next_exec_stall = data_sync_barrier;
                end else if (req_valid && !req_ready) begin
                    if (size_bad) begin
                        next_req_ready = 1'b1;
                        next_rsp_valid = 1'b1;
                        next_rsp_error = 1'b1;
                        next_hard_fault = 1'b1;
                    end else if (buf_full && !(req_mtype == MRAD_NORMAL && !req_write)) begin
                        // Wait for the buffered Device write first; every request waits,
                        // Normal reads and other words included, until it retires
                        next_state = state;
                    end else if (buf_full && req_addr[31:2] == bus_addr[31:2]) begin
                        next_state = state;
                    end else if (buf_full) begin
                        next_state = state;
                    end else begin
                        next_bus_valid = 1'b1;
                        next_bus_write = req_write;
                        next_bus_addr = req_addr;
                        next_bus_wdata = lane_wdata;
                        next_bus_strb = strb;
                        next_bus_mtype = req_mtype;
                        next_low_addr = req_addr[1:0];
                        next_low_size = req_size;
                        next_req_ready = 1'b1;
                        // Posted Device write frees the core now; strong never
                        // Shareable Device writes are not posted: one ordering rule is cheaper
                        if (req_write && req_mtype == MRAD_DEVICE && !req_shareable) begin
                            next_buf_full = 1'b1;
                            next_busy_buffered = 1'b1;
                            next_rsp_valid = 1'b1;
                        end else begin
                            next_busy_buffered = 1'b0;
                            next_state = MRAD_BUSY;
                        end
                    end
                end
            end
            MRAD_BUSY: begin
                if (bus_done) begin
                    next_bus_valid = 1'b0;
                    next_state = MRAD_IDLE;
                    next_rsp_valid = 1'b1;
                    next_rsp_error = bus_error;
                    next_rsp_rdata = bus_write ? 32'h00000000 : lane_rdata;
                    // A bus error must not mask a fetch fault of the same cycle
                    next_hard_fault = next_hard_fault || bus_error;
                end
            end
            MRAD_DRAIN: begin
                // Barrier completes only once nothing is buffered and the bus is idle
                if (!buf_full && !bus_valid) begin
                    next_state = MRAD_IDLE;
                    next_barrier_busy = 1'b0;
                    next_exec_stall = 1'b0;
                    next_bar_kind = 2'h0;
                end
            end
            default: next_state = MRAD_IDLE;
        endcase
        // Buffered write retires in the background
        if (buf_full && busy_buffered && bus_done) begin
            next_buf_full = 1'b0;
            next_busy_buffered = 1'b0;
            next_bus_valid = 1'b0;
            // Keep any fault already raised this cycle
            next_hard_fault = next_hard_fault || bus_error;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= MRAD_IDLE;
            buf_full <= 1'b0;
            busy_buffered <= 1'b0;
            bar_kind <= 2'h0;
            low_addr <= 2'h0;
            low_size <= 2'h0;
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_error <= 1'b0;
            rsp_rdata <= 32'h00000000;
            hard_fault_exception <= 1'b0;
            barrier_busy <= 1'b0;
            exec_stall <= 1'b0;
            prefetch_flush <= 1'b0;
            bus_valid <= 1'b0;
            bus_write <= 1'b0;
            bus_addr <= 32'h00000000;
            bus_wdata <= 32'h00000000;
            bus_strb <= 4'h0;
            bus_mtype <= MRAD_NORMAL;
        end else begin
            state <= next_state;
            buf_full <= next_buf_full;
            busy_buffered <= next_busy_buffered;
            bar_kind <= next_bar_kind;
            low_addr <= next_low_addr;
            low_size <= next_low_size;
            req_ready <= next_req_ready;
            rsp_valid <= next_rsp_valid;
            rsp_error <= next_rsp_error;
            rsp_rdata <= next_rsp_rdata;
            hard_fault_exception <= next_hard_fault;
            barrier_busy <= next_barrier_busy;
            exec_stall <= next_exec_stall;
            prefetch_flush <= next_prefetch_flush;
            bus_valid <= next_bus_valid;
            bus_write <= next_bus_write;
            bus_addr <= next_bus_addr;
            bus_wdata <= next_bus_wdata;
            bus_strb <= next_bus_strb;
            bus_mtype <= next_bus_mtype;
        end
    end
endmodule : mrad_top
`default_nettype wire
